// ### core/mnx_pkg.sv
// Constants, types and register map for the multiply / negate / no-op
// execution block of an 8-bit core.
// Assumes one 125 MHz clock, an Avalon-MM register port and a byte-wide
// data memory that lives inside the block.
package mnx_pkg;

    // Clock and phase timing
    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          PHASES_PER_CYC = 4;

    // Register byte offsets on the Avalon port
    localparam int          AVS_AW         = 6;
    localparam logic [5:0]  REG_INSTR      = 6'h00;
    localparam logic [5:0]  REG_WORK       = 6'h04;
    localparam logic [5:0]  REG_BANK_SEL   = 6'h08;
    localparam logic [5:0]  REG_CONFIG     = 6'h0c;
    localparam logic [5:0]  REG_STATUS     = 6'h10;
    localparam logic [5:0]  REG_PRODUCT    = 6'h14;
    localparam logic [5:0]  REG_IDX_BASE   = 6'h18;
    localparam logic [5:0]  REG_DMEM_ADDR  = 6'h1c;
    localparam logic [5:0]  REG_DMEM_DATA  = 6'h20;

    // Field positions
    localparam int          CFG_EXT_BIT    = 0;
    localparam int          INSTR_PEND_BIT = 16;
    localparam int          INSTR_OP_LSB   = 17;
    localparam int          FLAG_C_BIT     = 0;
    localparam int          FLAG_DC_BIT    = 1;
    localparam int          FLAG_Z_BIT     = 2;
    localparam int          FLAG_OV_BIT    = 3;
    localparam int          FLAG_N_BIT     = 4;

    // Reset values
    localparam logic [7:0]  WORK_RST       = 8'h00;
    localparam logic [15:0] PROD_RST       = 16'h0000;
    localparam logic [15:0] INSTR_RST      = 16'h0000;
    localparam logic        EXT_RST        = 1'b0;

    // Opcodes and addressing limits
    localparam logic [6:0]  OPC_MULTIPLY   = 7'h01;
    localparam logic [6:0]  OPC_NEGATE     = 7'h36;
    localparam logic [3:0]  OPC_NOP_HI     = 4'hf;
    localparam logic [7:0]  IDX_LIMIT      = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mnx_phase_e;
    typedef enum logic [1:0] {OP_NONE, OP_NOP, OP_MUL, OP_NEG} mnx_op_e;
    typedef enum logic [1:0] {BUS_IDLE, BUS_MEMRD, BUS_ACK} mnx_bus_e;

    // Arithmetic flags, packed so bit 0 is carry
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } mnx_flags_s;

    // One write port of the data memory
    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [7:0]  data;
    } mnx_mem_wr_s;

endpackage

// ### core/mnx_dmem.sv
// Byte-wide data memory with one write and one read port.
// Assumes callers never need the read data in the same cycle as the
// address; read data come out of a register one edge later.
`timescale 1ns/10ps
`default_nettype none
module mnx_dmem
    import mnx_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire mnx_mem_wr_s wr,
    input  wire logic        rd_en,
    input  wire logic [15:0] rd_addr,
    output var  logic [7:0]  rd_data_q
);

    logic [7:0] mem [0:(1<<AW)-1];

    generate
        if (AW < 9 || AW > 16) begin : g_bad_aw
            $error("mnx_dmem: AW must lie between 9 and 16");
        end
    endgenerate

    // Array holds no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem[wr.addr[AW-1:0]] <= wr.data;
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr[AW-1:0]];
        end
    end

endmodule
`default_nettype wire

// ### core/mnx_core.sv
// Execution block for multiply-by-file, negate-file and no-op words.
// Software loads the working register, bank select, configuration and
// data memory over Avalon-MM, then writes instruction words; each one
// runs in one four-phase instruction cycle.
// Assumes a single clock; all Avalon inputs are on that clock.
`timescale 1ns/10ps
`default_nettype none
module mnx_core
    import mnx_pkg::*;
#(
    parameter int BANK_BITS = 4
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [AVS_AW-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output var  logic [31:0]       avs_readdata,
    output var  logic              avs_waitrequest
);

    localparam int MAW = BANK_BITS + 8;

    generate
        if (BANK_BITS < 1 || BANK_BITS > 8) begin : g_bad_bank
            $error("mnx_core: BANK_BITS must lie between 1 and 8");
        end
    endgenerate

    mnx_phase_e        phase_q;
    mnx_bus_e          bus_q;
    mnx_op_e           op_q;
    mnx_flags_s        flags_q;
    mnx_flags_s        neg_flags_q;
    mnx_flags_s        neg_flags_d;
    mnx_mem_wr_s       mem_wr;
    logic [15:0]       instr_q;
    logic              pending_q;
    logic [15:0]       ir_q;
    logic [MAW-1:0]    ea_q;
    logic [7:0]        work_q;
    logic [BANK_BITS-1:0] bsr_q;
    logic              ext_en_q;
    logic [15:0]       prod_q;
    logic [15:0]       mul_q;
    logic [7:0]        neg_q;
    logic [7:0]        neg_d;
    logic [MAW-1:0]    idx_base_q;
    logic [MAW-1:0]    dm_addr_q;
    logic [31:0]       rdata_q;
    logic              wreq_q;
    logic [31:0]       reg_rd;
    logic              accept;
    logic              reg_wr;
    logic              sw_mem_rd;
    logic              mem_rd_en;
    logic [15:0]       mem_rd_addr;
    logic [7:0]        mem_rd_data;
    logic [31:0]       instr_mrg;
    logic [31:0]       prod_mrg;
    logic [31:0]       idx_mrg;
    logic [31:0]       dma_mrg;

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wreq_q;

    // Byte-enable merge of a write into a 32-bit register image
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // zero and 1111 words as no-op
    function automatic mnx_op_e decode_op(input logic [15:0] w);
        mnx_op_e r;
        if (w == 16'h0000 || w[15:12] == OPC_NOP_HI) begin
            r = OP_NOP;
        end else if (w[15:9] == OPC_MULTIPLY) begin
            r = OP_MUL;
        end else if (w[15:9] == OPC_NEGATE) begin
            r = OP_NEG;
        end else begin
            r = OP_NONE;    // Words outside this block do nothing here
        end
        return r;
    endfunction

    // Operand address from file address, bank bit and addressing mode
    function automatic logic [MAW-1:0] eff_addr(
        input logic [7:0]           f,
        input logic                 a,
        input logic                 ext,
        input logic [BANK_BITS-1:0] bank_select_register,
        input logic [MAW-1:0]       base);
        logic [MAW-1:0] fz;
        logic [MAW-1:0] r;
        fz = {{BANK_BITS{1'b0}}, f};
        if (a) begin
            r = {bank_select_register, f};
        end else if (ext && f <= IDX_LIMIT) begin
            r = base + fz;  // Wraps inside data memory on purpose
        end else if (f < ACCESS_SPLIT) begin
            r = fz;
        end else begin
            r = {{BANK_BITS{1'b1}}, f};
        end
        return r;
    endfunction

    // Byte-lane merges; a function result cannot be part-selected directly
    always_comb begin
        instr_mrg = be_merge({16'h0000, instr_q}, avs_writedata,
                             avs_byteenable);
        prod_mrg  = be_merge({16'h0000, prod_q}, avs_writedata,
                             avs_byteenable);
        idx_mrg   = be_merge(32'(idx_base_q), avs_writedata, avs_byteenable);
        dma_mrg   = be_merge(32'(dm_addr_q), avs_writedata, avs_byteenable);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= PH_Q1;
        end else begin
            case (phase_q)
                PH_Q1:   phase_q <= PH_Q2;
                PH_Q2:   phase_q <= PH_Q3;
                PH_Q3:   phase_q <= PH_Q4;
                PH_Q4:   phase_q <= PH_Q1;
                default: phase_q <= PH_Q1;
            endcase
        end
    end

    // One-word buffer between software and the pipeline; a full buffer
    // stalls the bus rather than dropping a word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_q <= 1'b0;
            instr_q   <= INSTR_RST;
        end else if (phase_q == PH_Q4 && pending_q) begin
            pending_q <= 1'b0;
        end else if (reg_wr && avs_address == REG_INSTR) begin
            pending_q <= 1'b1;
            instr_q   <= instr_mrg[15:0];
        end
    end

    // fetch at cycle end, idle cycles run as no-op
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ir_q <= 16'h0000;
        end else if (phase_q == PH_Q4) begin
            ir_q <= pending_q ? instr_q : 16'h0000;
        end
    end

    // decode and operand address in first phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_q <= OP_NOP;
            ea_q <= '0;
        end else if (phase_q == PH_Q1) begin
            op_q <= decode_op(ir_q);
            ea_q <= eff_addr(ir_q[7:0], ir_q[8], ext_en_q, bsr_q,
                             idx_base_q);
        end
    end

    // Data memory read port: core owns it in Q2, software elsewhere
    always_comb begin
        sw_mem_rd   = bus_q == BUS_IDLE && avs_read &&
                      avs_address == REG_DMEM_DATA && phase_q != PH_Q2;
        mem_rd_en   = 1'b0;
        mem_rd_addr = 16'(dm_addr_q);
        if (phase_q == PH_Q2) begin
            mem_rd_en   = op_q == OP_MUL || op_q == OP_NEG;
            mem_rd_addr = 16'(ea_q);
        end else if (sw_mem_rd) begin
            mem_rd_en   = 1'b1;
        end
    end

    always_comb begin
        logic [8:0] sum;
        logic [4:0] low;
        logic [7:0] inv;
        inv   = ~mem_rd_data;
        sum   = {1'b0, inv} + 9'h001;
        low   = {1'b0, inv[3:0]} + 5'h01;
        neg_d = sum[7:0];
        neg_flags_d.n  = sum[7];
        neg_flags_d.ov = ~inv[7] & sum[7];  // Only when operand is 80h
        neg_flags_d.z  = sum[7:0] == 8'h00;
        neg_flags_d.dc = low[4];
        neg_flags_d.c  = sum[8];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mul_q       <= PROD_RST;
            neg_q       <= 8'h00;
            neg_flags_q <= '0;
        end else if (phase_q == PH_Q3) begin
            mul_q       <= {8'h00, work_q} * {8'h00, mem_rd_data};
            neg_q       <= neg_d;
            neg_flags_q <= neg_flags_d;
        end
    end

    // Data memory write port: core in Q4, software in any other phase
    always_comb begin
        mem_wr      = '0;
        mem_wr.addr = 16'(dm_addr_q);
        mem_wr.data = avs_writedata[7:0];
        if (phase_q == PH_Q4) begin
            mem_wr.en   = op_q == OP_NEG;
            mem_wr.addr = 16'(ea_q);
            mem_wr.data = neg_q;
        end else begin
            mem_wr.en   = reg_wr && avs_address == REG_DMEM_DATA &&
                          avs_byteenable[0];
        end
    end

    mnx_dmem #(
        .AW        (MAW)
    ) u_dmem (
        .clk       (clk),
        .arst_n    (arst_n),
        .wr        (mem_wr),
        .rd_en     (mem_rd_en),
        .rd_addr   (mem_rd_addr),
        .rd_data_q (mem_rd_data)
    );

    // product pair written in last phase
    // multiply leaves flags alone
    // Core writeback beats a software write in the same edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prod_q  <= PROD_RST;
            flags_q <= '0;
        end else begin
            if (phase_q == PH_Q4 && op_q == OP_MUL) begin
                prod_q <= mul_q;
            end else if (reg_wr && avs_address == REG_PRODUCT) begin
                prod_q <= prod_mrg[15:0];
            end
            if (phase_q == PH_Q4 && op_q == OP_NEG) begin
                flags_q <= neg_flags_q;
            end else if (reg_wr && avs_address == REG_STATUS &&
                         avs_byteenable[0]) begin
                flags_q <= avs_writedata[4:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            work_q     <= WORK_RST;
            bsr_q      <= '0;
            ext_en_q   <= EXT_RST;
            idx_base_q <= '0;
            dm_addr_q  <= '0;
        end else if (reg_wr) begin
            case (avs_address)
                REG_WORK:
                    if (avs_byteenable[0]) begin
                        work_q <= avs_writedata[7:0];
                    end
                REG_BANK_SEL:
                    if (avs_byteenable[0]) begin
                        bsr_q <= avs_writedata[BANK_BITS-1:0];
                    end
                REG_CONFIG:
                    if (avs_byteenable[0]) begin
                        ext_en_q <= avs_writedata[CFG_EXT_BIT];
                    end
                REG_IDX_BASE:
                    idx_base_q <= idx_mrg[MAW-1:0];
                REG_DMEM_ADDR:
                    dm_addr_q  <= dma_mrg[MAW-1:0];
                default: ;
            endcase
        end
    end

    // Register read image; unmapped offsets read as zero
    always_comb begin
        reg_rd = 32'h0000_0000;
        case (avs_address)
            REG_INSTR: begin
                reg_rd[15:0]           = instr_q;
                reg_rd[INSTR_PEND_BIT] = pending_q;
                reg_rd[INSTR_OP_LSB +: 2] = op_q;
            end
            REG_WORK:      reg_rd[7:0]           = work_q;
            REG_BANK_SEL:  reg_rd[BANK_BITS-1:0] = bsr_q;
            REG_CONFIG:    reg_rd[CFG_EXT_BIT]   = ext_en_q;
            REG_STATUS:    reg_rd[4:0]           = flags_q;
            REG_PRODUCT:   reg_rd[15:0]          = prod_q;
            REG_IDX_BASE:  reg_rd[MAW-1:0]       = idx_base_q;
            REG_DMEM_ADDR: reg_rd[MAW-1:0]       = dm_addr_q;
            default:       reg_rd                = 32'h0000_0000;
        endcase
    end

    // Accept a request unless it needs a port the core holds this phase
    // or the instruction buffer is still full
    always_comb begin
        accept = 1'b0;
        if (bus_q == BUS_IDLE && (avs_read || avs_write)) begin
            if (avs_address == REG_DMEM_DATA) begin
                accept = avs_write && phase_q != PH_Q4;
            end else if (avs_write && avs_address == REG_INSTR) begin
                accept = !pending_q;
            end else begin
                accept = 1'b1;
            end
        end
        reg_wr = accept && avs_write;
    end

    // Avalon slave handshake: waitrequest drops for exactly one cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_q   <= BUS_IDLE;
            wreq_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            case (bus_q)
                BUS_IDLE:
                    if (sw_mem_rd) begin
                        bus_q <= BUS_MEMRD;
                    end else if (accept) begin
                        wreq_q  <= 1'b0;
                        rdata_q <= avs_read ? reg_rd : 32'h0000_0000;
                        bus_q   <= BUS_ACK;
                    end
                BUS_MEMRD: begin
                    wreq_q  <= 1'b0;
                    rdata_q <= {24'h000000, mem_rd_data};
                    bus_q   <= BUS_ACK;
                end
                BUS_ACK: begin
                    wreq_q <= 1'b1;
                    bus_q  <= BUS_IDLE;
                end
                default: begin
                    wreq_q <= 1'b1;
                    bus_q  <= BUS_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### dv/mnx_core_assertions.sv
// Checker for the execution block, watching only its Avalon port.
// Assumes one clock and the asynchronous active-low reset of the core.
`timescale 1ns/10ps
`default_nettype none
module mnx_core_assertions
    import mnx_pkg::*;
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [AVS_AW-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [7:0]  work_q;
    logic [15:0] instr_q;

    // Shadows of software-owned registers; the core never writes them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            work_q  <= 8'h00;
            instr_q <= 16'h0000;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == REG_WORK && avs_byteenable[0])
                work_q <= avs_writedata[7:0];
            if (avs_address == REG_INSTR && avs_byteenable[0])
                instr_q[7:0] <= avs_writedata[7:0];
            if (avs_address == REG_INSTR && avs_byteenable[1])
                instr_q[15:8] <= avs_writedata[15:8];
        end
    end

    sequence req_waiting;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rd_at(logic [5:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence

    ack_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    ack_has_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("acknowledge without a request");
    ack_bounded_a: assert property (req_waiting |-> ##[0:12] !avs_waitrequest)
        else $error("request not answered in time");
    work_kept_a: assert property (rd_at(REG_WORK) |-> avs_readdata == {24'h0, work_q})
        else $error("working register changed by the core");
    instr_echo_a: assert property (rd_at(REG_INSTR) |-> avs_readdata[15:0] == instr_q)
        else $error("instruction word readback wrong");
    prod_narrow_a: assert property (rd_at(REG_PRODUCT) |-> avs_readdata[31:16] == 16'h0)
        else $error("product upper bits not zero");
    bank_narrow_a: assert property (rd_at(REG_BANK_SEL) |-> avs_readdata[31:4] == 28'h0)
        else $error("bank select upper bits not zero");
    cfg_narrow_a: assert property (rd_at(REG_CONFIG) |-> avs_readdata[31:1] == 31'h0)
        else $error("config upper bits not zero");
    flags_narrow_a: assert property (rd_at(REG_STATUS) |-> avs_readdata[31:5] == 27'h0)
        else $error("status upper bits not zero");
endmodule

bind mnx_core mnx_core_assertions u_chk (
    .clk             (clk),
    .arst_n          (arst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
);
`default_nettype wire

// ### dv/mnx_core_tb.sv
// Self-checking bench for the execution block, driven over Avalon-MM.
// Assumes the checker is bound in and data memory is written before use.
`timescale 1ns/10ps
`default_nettype none
module mnx_core_tb
    import mnx_pkg::*;
;
    logic              clk;
    logic              arst_n;
    logic [AVS_AW-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    int                err_total;
    int                tests_run;
    int                cyc;
    logic [31:0]       rd;
    logic [31:0]       p0;
    logic [31:0]       s0;
    logic [7:0]        fv [3] = '{8'hb5, 8'hff, 8'h7e};
    logic [7:0]        wv [3] = '{8'hc4, 8'hff, 8'h00};
    logic [7:0]        fa [3] = '{8'h45, 8'hff, 8'h00};
    logic [7:0]        nv [5] = '{8'h3a, 8'h00, 8'h80, 8'h01, 8'hf0};
    logic [7:0]        nf [5] = '{8'h20, 8'h90, 8'h7f, 8'h80, 8'h05};
    logic [15:0]       nop_w [3] = '{16'h0000, 16'hf123, 16'hffff};
    logic [11:0]       ad;

    mnx_core dut (
        .clk             (clk),
        .arst_n          (arst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    // Free-running 125 MHz clock
    always #4 clk = ~clk;

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard: the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= 4'hf;
        avs_write      <= wr;
        avs_read       <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) err_total++;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
        wr(REG_DMEM_ADDR, {20'h0, a});
        wr(REG_DMEM_DATA, {24'h0, d});
    endtask

    task automatic mem_get(input logic [11:0] a, output logic [31:0] q);
        wr(REG_DMEM_ADDR, {20'h0, a});
        xfer(1'b0, REG_DMEM_DATA, 32'h0, q);
    endtask

    // A word completes within 8 cycles of being accepted; its class stands
    // one instruction cycle, so a read every 3 cycles cannot miss it
    task automatic run(input logic [15:0] w, input logic [1:0] cls);
        logic [31:0] q;
        wr(REG_INSTR, {16'h0, w});
        for (int k = 0; k < 4; k++) begin
            xfer(1'b0, REG_INSTR, 32'h0, q);
            if (q[18:17] == cls) break;
        end
        chk("class", {30'h0, q[18:17]}, {30'h0, cls});
        repeat (10) @(posedge clk);
    endtask

    // Status after negation: N4 OV3 Z2 DC1 C0
    function automatic logic [31:0] neg_flags(input logic [7:0] v);
        logic [7:0] r;
        r = ~v + 8'h01;
        return {27'h0, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0,
                v == 8'h00};
    endfunction

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        err_total = 0;
        tests_run = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        xfer(1'b0, REG_PRODUCT, 32'h0, rd);
        chk("product reset", rd, 32'h0);
        // Multiply through the bank select path, flags preset to all ones
        wr(REG_BANK_SEL, 32'h3);
        wr(REG_STATUS, 32'h1f);
        for (int i = 0; i < 3; i++) begin
            mem_set({4'h3, fa[i]}, fv[i]);
            wr(REG_WORK, {24'h0, wv[i]});
            run({8'h03, fa[i]}, 2'h2);
            xfer(1'b0, REG_PRODUCT, 32'h0, rd);
            chk("product", rd, {16'h0, 16'(wv[i]) * 16'(fv[i])});
            xfer(1'b0, REG_WORK, 32'h0, rd);
            chk("work", rd, {24'h0, wv[i]});
            mem_get({4'h3, fa[i]}, rd);
            chk("source byte", rd, {24'h0, fv[i]});
            xfer(1'b0, REG_STATUS, 32'h0, rd);
            chk("mul flags", rd, 32'h1f);
            xfer(1'b0, REG_INSTR, 32'h0, rd);
            // Idle cycles after the word decode as no-op
            chk("mul class", rd[18:17], 32'h1);
        end
        // Negate through the access bank, both halves
        for (int i = 0; i < 5; i++) begin
            ad = nf[i] < ACCESS_SPLIT ? {4'h0, nf[i]} : {4'hf, nf[i]};
            mem_set(ad, nv[i]);
            run({8'h6c, nf[i]}, 2'h3);
            mem_get(ad, rd);
            chk("neg result", rd, {24'h0, ~nv[i] + 8'h01});
            xfer(1'b0, REG_STATUS, 32'h0, rd);
            chk("neg flags", rd, neg_flags(nv[i]));
            xfer(1'b0, REG_INSTR, 32'h0, rd);
            chk("neg class", rd[18:17], 32'h1);
        end
        // Indexed offset at the 5Fh boundary, two words back to back
        wr(REG_CONFIG, 32'h1);
        wr(REG_IDX_BASE, 32'h200);
        mem_set(12'h25f, 8'h11);
        mem_set(12'h060, 8'h22);
        wr(REG_INSTR, 32'h6c5f);
        wr(REG_INSTR, 32'h6c60);
        repeat (20) @(posedge clk);
        mem_get(12'h25f, rd);
        chk("indexed", rd, 32'hef);
        mem_get(12'h060, rd);
        chk("above index", rd, 32'hde);
        wr(REG_CONFIG, 32'h0);
        // No-op words leave product, flags and memory alone
        xfer(1'b0, REG_PRODUCT, 32'h0, p0);
        xfer(1'b0, REG_STATUS, 32'h0, s0);
        for (int i = 0; i < 3; i++) begin
            run(nop_w[i], 2'h1);
            xfer(1'b0, REG_PRODUCT, 32'h0, rd);
            chk("nop product", rd, p0);
            xfer(1'b0, REG_STATUS, 32'h0, rd);
            chk("nop flags", rd, s0);
            mem_get(12'h060, rd);
            chk("nop memory", rd, 32'hde);
            xfer(1'b0, REG_INSTR, 32'h0, rd);
            chk("nop class", rd[18:17], 32'h1);
        end
        conclude();
    end
endmodule
`default_nettype wire
